//--- bls_core.sv
// Behaviour
// RULE1: PC writes except branch clear PC bit eight
// RULE2: Port read-modify-write uses pin levels
// RULE3: Direction load six copies accumulator to port
// RULE4: Timer register writes clear assigned prescaler
// RULE5: Add sums accumulator and file, sets flags
// RULE6: Destination bit picks accumulator or file
// RULE7: Bit clear zeroes chosen bit, flags kept
// RULE8: Bit set raises chosen bit, flags kept
// RULE9: And literal updates accumulator and zero only
// RULE10: And file updates destination and zero only
// RULE11: Test skips next when bit is zero
// RULE12: Test skips next when bit is one
// RULE13: Skipped instruction runs as no-operation
// RULE14: Clear accumulator zeroes it, sets zero flag
// RULE15: Four clocks per cycle, two on PC change
// RULE16: Zero, carry, digit carry computed correctly
`timescale 1ns/10ps
`default_nettype none
module bls_core (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Register bus.
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Second port pins.
  input wire logic [7:0] i_port_pins,
  output logic [7:0] o_port_out,
  output logic [7:0] o_port_oe,
  output logic [7:0] o_port_dir,
  // Timer prescaler.
  input wire logic i_presc_on_timer,
  output logic o_presc_clr
);

  // Opcode decoding, shared by execution and checks.
  function automatic bls_pkg::bls_op_e op_decode(input logic [11:0] ins);
    bls_pkg::bls_op_e op;
    op = bls_pkg::OP_NOP;
    if (ins[11:6] == 6'h07) op = bls_pkg::OP_ADD;
    else if (ins[11:6] == 6'h05) op = bls_pkg::OP_ANDF;
    else if (ins[11:8] == 4'he) op = bls_pkg::OP_ANDL;
    else if (ins[11:8] == 4'h4) op = bls_pkg::OP_BCLR;
    else if (ins[11:8] == 4'h5) op = bls_pkg::OP_BSET;
    else if (ins[11:8] == 4'h6) op = bls_pkg::OP_TSTZ;
    else if (ins[11:8] == 4'h7) op = bls_pkg::OP_TST1;
    else if (ins == 12'h040) op = bls_pkg::OP_CLEAR_ACCUM;
    else if (ins[11:3] == 9'h000) op = bls_pkg::OP_DIR_LOAD;
    return op;
  endfunction

  bls_pkg::bls_state_e state_q, state_d;
  logic [1:0] phase_q;
  logic [11:0] instr_q;
  logic [7:0] acc_q;
  logic [9:0] pc_q;
  logic [4:0] fsel_q;
  logic skip_q, disc_q;
  logic [7:0] dir_q, oe_q;
  logic presc_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [7:0] file_q [bls_pkg::FILE_DEPTH];

  // Operand fields.
  wire [4:0] f_idx = instr_q[4:0];
  wire d_bit = instr_q[5];
  wire [2:0] b_idx = instr_q[7:5];
  wire [7:0] k_lit = instr_q[7:0];

  // A discarded instruction after a taken skip executes as a no-op.
  wire bls_pkg::bls_op_e op_v = disc_q ? bls_pkg::OP_NOP
                                       : op_decode(instr_q); // [RULE13]
  wire commit = (state_q == bls_pkg::ST_EXEC) &&
                (phase_q == bls_pkg::CYC_LAST);

  // Source operand; port reads see the pins, not the output latch.
  wire [7:0] src_v = (f_idx == bls_pkg::IDX_PORT) ? i_port_pins :
                     (f_idx == bls_pkg::IDX_PCL) ? pc_q[7:0] :
                     file_q[f_idx]; // [RULE2]

  // Arithmetic and logic.
  wire [8:0] sum9 = {1'b0, acc_q} + {1'b0, src_v}; // [RULE5]
  wire [4:0] hsum = {1'b0, acc_q[3:0]} + {1'b0, src_v[3:0]};
  wire [7:0] bmask = 8'h01 << b_idx;
  wire is_add = (op_v == bls_pkg::OP_ADD);
  wire is_andf = (op_v == bls_pkg::OP_ANDF);
  wire is_bit = (op_v == bls_pkg::OP_BCLR) || (op_v == bls_pkg::OP_BSET);
  wire [7:0] res_v =
    is_add ? sum9[7:0] :
    is_andf ? (acc_q & src_v) : // [RULE10]
    (op_v == bls_pkg::OP_ANDL) ? (acc_q & k_lit) : // [RULE9]
    (op_v == bls_pkg::OP_BCLR) ? (src_v & ~bmask) : // [RULE7]
    (op_v == bls_pkg::OP_BSET) ? (src_v | bmask) : // [RULE8]
    8'h00; // [RULE14]
  wire bls_pkg::bls_alu_s alu = '{res: res_v, c: sum9[8],
                                   half_nibble_flag: hsum[4],
                                   z: (res_v == 8'h00)}; // [RULE16]

  // Destinations and flag updates.
  wire wr_file = ((is_add || is_andf) && d_bit) || is_bit; // [RULE6]
  wire wr_acc = ((is_add || is_andf) && !d_bit) ||
                (op_v == bls_pkg::OP_ANDL) ||
                (op_v == bls_pkg::OP_CLEAR_ACCUM); // [RULE6]
  wire upd_z = is_add || is_andf || (op_v == bls_pkg::OP_ANDL) ||
               (op_v == bls_pkg::OP_CLEAR_ACCUM);
  wire pc_wr = commit && wr_file && (f_idx == bls_pkg::IDX_PCL);
  wire skip_take = ((op_v == bls_pkg::OP_TSTZ) && !src_v[b_idx]) ||
                   ((op_v == bls_pkg::OP_TST1) && src_v[b_idx]);
  wire timer_hit = commit && wr_file && (f_idx == bls_pkg::IDX_TIMER);
  wire dir_load_hit = commit && (op_v == bls_pkg::OP_DIR_LOAD) &&
                      (instr_q[2:0] == bls_pkg::DIR_LOAD_PORT_SEL);

  // Register bus decode. Writes wait while an instruction runs so the
  // core state never changes under software's feet.
  wire busy = (state_q != bls_pkg::ST_IDLE);
  wire a_instr = (i_paddr == bls_pkg::OFS_INSTR);
  wire a_accum = (i_paddr == bls_pkg::OFS_ACCUM);
  wire a_core = (i_paddr == bls_pkg::OFS_CORE);
  wire a_pc = (i_paddr == bls_pkg::OFS_PC);
  wire a_fsel = (i_paddr == bls_pkg::OFS_FSEL);
  wire a_fdata = (i_paddr == bls_pkg::OFS_FDATA);
  wire mapped = a_instr || a_accum || a_core || a_pc || a_fsel || a_fdata;
  wire bus_take = i_psel && i_penable && !pready_q && !(i_pwrite && busy);
  wire bus_wr = i_psel && i_penable && pready_q && i_pwrite && !pslverr_q;
  wire start = bus_wr && a_instr;
  wire [7:0] fsel_rd = (fsel_q == bls_pkg::IDX_PORT) ? i_port_pins :
                       file_q[fsel_q];
  wire [31:0] rd_v =
    a_instr ? {20'h00000, instr_q} :
    a_accum ? {24'h000000, acc_q} :
    a_core ? {30'h00000000, skip_q, busy} :
    a_pc ? {22'h000000, pc_q} :
    a_fsel ? {27'h0000000, fsel_q} :
    a_fdata ? {24'h000000, fsel_rd} : 32'h00000000;

  // Sequencer: four clocks per instruction cycle, one more cycle
  // when the program counter is written.
  always_comb begin
    state_d = state_q;
    case (state_q)
      bls_pkg::ST_IDLE: begin
        if (start) state_d = bls_pkg::ST_EXEC;
      end
      bls_pkg::ST_EXEC: begin
        if (commit) begin
          state_d = pc_wr ? bls_pkg::ST_STALL : bls_pkg::ST_IDLE; // [RULE15]
        end
      end
      bls_pkg::ST_STALL: begin
        if (phase_q == bls_pkg::CYC_LAST) state_d = bls_pkg::ST_IDLE;
      end
      default: state_d = bls_pkg::ST_IDLE;
    endcase
  end

  // State and phase counter.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_q <= bls_pkg::ST_IDLE;
      phase_q <= 2'h0;
    end else begin
      state_q <= state_d;
      phase_q <= busy ? phase_q + 2'h1 : 2'h0; // [RULE15]
    end
  end

  // Instruction latch and skip tracking; a new skip is set only at
  // commit, which never meets a start, so no event is lost.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      instr_q <= 12'h000;
      skip_q <= 1'b0;
      disc_q <= 1'b0;
    end else if (start) begin
      instr_q <= i_pwdata[11:0];
      disc_q <= skip_q; // [RULE13]
      skip_q <= 1'b0;
    end else if (commit) begin
      skip_q <= skip_take; // [RULE11] [RULE12]
    end
  end

  // Accumulator.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) acc_q <= 8'h00;
    else if (commit && wr_acc) acc_q <= alu.res; // [RULE6]
    else if (bus_wr && a_accum) acc_q <= i_pwdata[7:0];
  end

  // Program counter; a computed write clears bit eight.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) pc_q <= bls_pkg::RST_PC;
    else if (pc_wr) pc_q <= {pc_q[9], 1'b0, alu.res}; // [RULE1]
    else if (commit) pc_q <= pc_q + 10'h001;
  end

  // File registers; the status entry takes flags over any data write.
  for (genvar gi = 0; gi < bls_pkg::FILE_DEPTH; gi++) begin : g_file
    wire hit = commit && wr_file && (f_idx == 5'(gi));
    wire sw = bus_wr && a_fdata && (fsel_q == 5'(gi));
    if (gi == int'(bls_pkg::IDX_STATUS)) begin : g_stat
      wire [7:0] base = hit ? alu.res : sw ? i_pwdata[7:0] : file_q[gi];
      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
          file_q[gi] <= 8'h00;
        end else begin
          file_q[gi] <= base;
          if (commit && upd_z) file_q[gi][bls_pkg::FLG_Z] <= alu.z;
          if (commit && is_add) begin
            file_q[gi][bls_pkg::FLG_C] <= alu.c; // [RULE5]
            file_q[gi][bls_pkg::FLG_HALF_NIBBLE] <= alu.half_nibble_flag;
          end
        end
      end
    end else begin : g_plain
      always_ff @(posedge i_mclk) begin
        if (i_sys_rst) file_q[gi] <= 8'h00;
        else if (hit) file_q[gi] <= alu.res; // [RULE6]
        else if (sw) file_q[gi] <= i_pwdata[7:0];
      end
    end
  end

  // Direction latches, output enables and prescaler clear pulse.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      dir_q <= bls_pkg::RST_DIR;
      oe_q <= ~bls_pkg::RST_DIR;
      presc_q <= 1'b0;
    end else begin
      if (dir_load_hit) begin
        dir_q <= acc_q; // [RULE3]
        oe_q <= ~acc_q;
      end
      presc_q <= timer_hit && i_presc_on_timer; // [RULE4]
    end
  end

  // Bus slave: one wait state, more for a write while an instruction runs, then a registered answer.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
      fsel_q <= 5'h00;
    end else begin
      pready_q <= bus_take;
      pslverr_q <= bus_take && !mapped;
      if (bus_take) prdata_q <= rd_v;
      if (bus_wr && a_fsel) fsel_q <= i_pwdata[4:0];
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_port_out = file_q[bls_pkg::IDX_PORT];
  assign o_port_dir = dir_q;
  assign o_port_oe = oe_q;
  assign o_presc_clr = presc_q;

  // Checks of the execute behaviour.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);

  property p_pc8;
    pc_wr |=> (pc_q[8] == 1'b0) && (pc_q[7:0] == $past(alu.res));
  endproperty
  a_pc8: assert property (p_pc8) // [RULE1]
    else $error("PC bit eight not cleared");

  property p_dir_load;
    dir_load_hit |=> (dir_q == $past(acc_q)) && (oe_q == ~dir_q);
  endproperty
  a_dir_load: assert property (p_dir_load) // [RULE3]
    else $error("Direction latch not loaded");

  property p_presc;
    (timer_hit && i_presc_on_timer) |=> o_presc_clr;
  endproperty
  a_presc: assert property (p_presc) // [RULE4]
    else $error("Prescaler clear missing");

  property p_add;
    (commit && is_add && !d_bit) |=>
      acc_q == 8'($past(acc_q) + $past(src_v));
  endproperty
  a_add: assert property (p_add) // [RULE5]
    else $error("Add result wrong");

  property p_bclr;
    (commit && op_v == bls_pkg::OP_BCLR && f_idx > bls_pkg::IDX_STATUS &&
     f_idx != bls_pkg::IDX_PORT) |=>
      file_q[$past(f_idx)][$past(b_idx)] == 1'b0;
  endproperty
  a_bclr: assert property (p_bclr) // [RULE7]
    else $error("Bit clear failed");

  property p_andl;
    (commit && op_v == bls_pkg::OP_ANDL) |=>
      acc_q == ($past(acc_q) & $past(k_lit));
  endproperty
  a_andl: assert property (p_andl) // [RULE9]
    else $error("And literal wrong");

  property p_skip;
    (commit && op_v == bls_pkg::OP_TSTZ && !src_v[b_idx]) |=> skip_q;
  endproperty
  a_skip: assert property (p_skip) // [RULE11]
    else $error("Skip not taken");

  property p_clear_accum;
    (commit && op_v == bls_pkg::OP_CLEAR_ACCUM) |=>
      acc_q == 8'h00 && file_q[bls_pkg::IDX_STATUS][bls_pkg::FLG_Z];
  endproperty
  a_clear_accum: assert property (p_clear_accum) // [RULE14]
    else $error("Clear accumulator wrong");

  property p_cycle;
    $rose(state_q == bls_pkg::ST_EXEC) |->
      (state_q == bls_pkg::ST_EXEC) [*4] ##1 !(state_q == bls_pkg::ST_EXEC);
  endproperty
  a_cycle: assert property (p_cycle) // [RULE15]
    else $error("Instruction cycle not four clocks");

  // A program counter write costs a whole second instruction cycle.
  property p_stall;
    pc_wr |=> (state_q == bls_pkg::ST_STALL) [*4] ##1
      (state_q == bls_pkg::ST_IDLE);
  endproperty
  a_stall: assert property (p_stall) // [RULE15]
    else $error("Program counter write not stalled one cycle");

  property p_zero;
    (commit && is_andf && !d_bit) |=>
      file_q[bls_pkg::IDX_STATUS][bls_pkg::FLG_Z] == (acc_q == 8'h00);
  endproperty
  a_zero: assert property (p_zero) // [RULE16]
    else $error("Zero flag wrong");

  c_add: cover property (commit && is_add && d_bit);
  c_skip: cover property (commit && skip_take);
  c_dir_load: cover property (dir_load_hit);
  c_pcw: cover property (pc_wr);

endmodule // bls_core
`default_nettype wire

//--- bls_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module bls_core_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] port_pins = 8'h00;
  logic presc_on = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] port_out;
  logic [7:0] port_oe;
  logic [7:0] port_dir;
  logic presc_clr;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int presc_n = 0;
  logic [9:0] exp_pc = 10'h000;
  logic [31:0] rdv;
  logic errv;

  bls_core u_bls_core (
    .i_mclk(mclk), .i_sys_rst(sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_port_pins(port_pins),
    .o_port_out(port_out), .o_port_oe(port_oe), .o_port_dir(port_dir),
    .i_presc_on_timer(presc_on), .o_presc_clr(presc_clr)
  );

  // The clock toggles every half period of 5 ns.
  always #5 mclk = ~mclk;

  // Counts prescaler clear pulses; a missed or doubled pulse shows here.
  always @(posedge mclk) begin
    if (presc_clr === 1'b1) presc_n++;
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      results();
    end
  end

  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic setf(input logic [4:0] f, input logic [7:0] v);
    apb(1'b1, bls_pkg::OFS_FSEL, {27'h0, f});
    apb(1'b1, bls_pkg::OFS_FDATA, {24'h0, v});
  endtask

  task automatic getf(input logic [4:0] f);
    apb(1'b1, bls_pkg::OFS_FSEL, {27'h0, f});
    apb(1'b0, bls_pkg::OFS_FDATA, 32'h0);
  endtask

  task automatic acc(input logic [7:0] v);
    apb(1'b1, bls_pkg::OFS_ACCUM, {24'h0, v});
  endtask

  // Issues one opcode and polls the busy bit with a bounded count.
  task automatic exec(input logic [11:0] op);
    int n;
    n = 0;
    apb(1'b1, bls_pkg::OFS_INSTR, {20'h0, op});
    exp_pc = exp_pc + 10'h001;
    do begin
      apb(1'b0, bls_pkg::OFS_CORE, 32'h0);
      n++;
    end while (rdv[0] !== 1'b0 && n < 20);
    if (n >= 20) fail_count++;
  endtask

  function automatic logic [11:0] op(input logic [11:0] base,
                                     input logic [2:0] m,
                                     input logic [4:0] f);
    return base | {4'h0, m, f};
  endfunction

  initial begin
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    chk({24'h0, port_dir}, 32'hff);
    chk({24'h0, port_oe}, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, errv}, 32'h1);
    chk(rdv, 32'h0);
    // Sum with both carries and a zero result, then into the file.
    acc(8'h8f);
    setf(5'd8, 8'h71);
    exec(op(12'h1c0, 3'h0, 5'd8));
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h0);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h7);
    acc(8'h05);
    setf(5'd8, 8'h03);
    exec(op(12'h1c0, 3'h1, 5'd8));
    getf(5'd8);
    chk(rdv, 32'h08);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h0);
    // AND into the file keeps carry, then AND with a literal.
    acc(8'h0f);
    setf(5'd10, 8'hf0);
    setf(bls_pkg::IDX_STATUS, 8'h01);
    exec(op(12'h140, 3'h1, 5'd10));
    getf(5'd10);
    chk(rdv, 32'h0);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h5);
    exec(12'he3c);
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h0c);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h1);
    // Every bit position is set and cleared with the flags all high.
    setf(bls_pkg::IDX_STATUS, 8'h07);
    setf(5'd9, 8'h00);
    for (int b = 0; b < 8; b++) begin
      exec(op(12'h500, 3'(b), 5'd9));
      getf(5'd9);
      chk(rdv, 32'h1 << b);
      exec(op(12'h400, 3'(b), 5'd9));
      getf(5'd9);
      chk(rdv, 32'h0);
    end
    // Taken skips discard the next opcode; untaken ones do not.
    setf(5'd9, 8'h08);
    acc(8'h55);
    exec(op(12'h700, 3'h3, 5'd9));
    apb(1'b0, bls_pkg::OFS_CORE, 32'h0);
    chk(rdv & 32'h3, 32'h2);
    exec(12'he00);
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h55);
    exec(op(12'h600, 3'h3, 5'd9));
    exec(12'he0f);
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h05);
    exec(op(12'h600, 3'h2, 5'd9));
    exec(12'he00);
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h05);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h3);
    // Clearing the accumulator raises zero from a cleared status.
    setf(bls_pkg::IDX_STATUS, 8'h00);
    exec(12'h040);
    apb(1'b0, bls_pkg::OFS_ACCUM, 32'h0);
    chk(rdv, 32'h0);
    getf(bls_pkg::IDX_STATUS);
    chk(rdv & 32'h7, 32'h4);
    // Direction load and a port read that must come from the pins.
    acc(8'h5a);
    exec(12'h006);
    chk({24'h0, port_dir}, 32'h5a);
    chk({24'h0, port_oe}, 32'ha5);
    port_pins <= 8'h3c;
    setf(bls_pkg::IDX_PORT, 8'hff);
    acc(8'hff);
    exec(op(12'h140, 3'h1, bls_pkg::IDX_PORT));
    chk({24'h0, port_out}, 32'h3c);
    // Prescaler clear only for a file write with the prescaler assigned.
    setf(bls_pkg::IDX_TIMER, 8'h00);
    presc_on <= 1'b1;
    exec(op(12'h500, 3'h0, bls_pkg::IDX_TIMER));
    chk(32'(presc_n), 32'h1);
    exec(op(12'h1c0, 3'h0, bls_pkg::IDX_TIMER));
    presc_on <= 1'b0;
    exec(op(12'h500, 3'h1, bls_pkg::IDX_TIMER));
    chk(32'(presc_n), 32'h1);
    // Run the counter past bit 8, then write the low byte of it.
    while (exp_pc < 10'h101) exec(12'h000);
    apb(1'b0, bls_pkg::OFS_PC, 32'h0);
    chk(rdv, {22'h0, exp_pc});
    acc(8'h00);
    exec(op(12'h140, 3'h1, bls_pkg::IDX_PCL));
    apb(1'b0, bls_pkg::OFS_PC, 32'h0);
    chk(rdv, 32'h0);
    results();
  end
endmodule // bls_core_tb
`default_nettype wire

//--- bls_pkg.sv
`default_nettype none
package bls_pkg;

  // Operation classes recognised by the execute stage.
  typedef enum logic [3:0] {
    OP_NOP, OP_ADD, OP_ANDF, OP_ANDL, OP_BCLR,
    OP_BSET, OP_TSTZ, OP_TST1, OP_CLEAR_ACCUM, OP_DIR_LOAD
  } bls_op_e;

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_EXEC = 3'h2,
    ST_STALL = 3'h4
  } bls_state_e;

  // Result of the execute stage with its flags.
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic half_nibble_flag;
    logic z;
  } bls_alu_s;

  // Register byte offsets on the bus.
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACCUM = 8'h04;
  localparam logic [7:0] OFS_CORE = 8'h08;
  localparam logic [7:0] OFS_PC = 8'h0c;
  localparam logic [7:0] OFS_FSEL = 8'h10;
  localparam logic [7:0] OFS_FDATA = 8'h14;

  // File register indices with special meaning.
  localparam logic [4:0] IDX_TIMER = 5'h01;
  localparam logic [4:0] IDX_PCL = 5'h02;
  localparam logic [4:0] IDX_STATUS = 5'h03;
  localparam logic [4:0] IDX_PORT = 5'h06;
  localparam int FILE_DEPTH = 32;

  // Flag positions in the status file register.
  localparam int FLG_C = 0;
  localparam int FLG_HALF_NIBBLE = 1;
  localparam int FLG_Z = 2;

  // Operand field of the direction load for the second port.
  localparam logic [2:0] DIR_LOAD_PORT_SEL = 3'h6;

  // Reset values.
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [9:0] RST_PC = 10'h000;

  // Index of the last oscillator period in an instruction cycle.
  localparam logic [1:0] CYC_LAST = 2'h3;

endpackage
`default_nettype wire
